/* File: verif/tb_windowed_watchdog_timer.sv */
`timescale 1ns/1ps
`include "wwdt_regs.vh"

module tb_windowed_watchdog_timer;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg debug_state = 1'b0;
    reg idle_state = 1'b0;
    reg sw_rst = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    wire [31:0] reg_rdata;
    wire irq, wdt_fault, reset_all_req, reset_proc_req;
    wire slow_clk_in, proc_rst_n;
    integer err_count = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer i;
    integer k;

    // 50 MHz
    always #10 clk = ~clk;

    wwdt_top wwdt_top_inst (.clk(clk), .rstn(rstn),
        .slow_clk_in(slow_clk_in), .proc_rst_n(proc_rst_n),
        .debug_state(debug_state), .idle_state(idle_state),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .wdt_fault(wdt_fault), .reset_all_req(reset_all_req),
        .reset_proc_req(reset_proc_req));
    wwdt_rstc_model wwdt_rstc_model_inst (.clk(clk), .rstn(rstn),
        .reset_all_req(reset_all_req), .reset_proc_req(reset_proc_req),
        .sw_rst(sw_rst), .slow_clk_in(slow_clk_in),
        .proc_rst_n(proc_rst_n));

    task chk(input string n, input [31:0] e, input [31:0] s);
        samples_checked = samples_checked + 1;
        if (s !== e)
        begin
            err_count = err_count + 1;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, input [31:0] e, input string n);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata);
    endtask
    // outputs trail the state by one cycle
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task wait_ev(input integer n);
        for (i = 0; i < n && irq !== 1'b1 && reset_all_req !== 1'b1
            && reset_proc_req !== 1'b1; i = i + 1)
            @(posedge clk) #1;
    endtask
    task tally_and_finish;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // the whole run needs about 9000 cycles
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(`WWDT_OFF_MODE, `WWDT_MODE_RESET, "mode");
        rd(`WWDT_OFF_STAT, 32'h0, "status");
        rd(`WWDT_OFF_IRQ_STAT, 32'h00000300, "irqreg");
        rd(4'h3, 32'h0, "unmapped");
        // short period, narrow window; second mode write is dropped
        wr(`WWDT_OFF_MODE, 32'h00011003);
        wr(`WWDT_OFF_MODE, 32'h0000000F);
        rd(`WWDT_OFF_MODE, 32'h00011003, "mode");
        wr(`WWDT_OFF_CTRL, 32'h5A000001);
        rd(`WWDT_OFF_STAT, 32'h0, "status");
        wr(`WWDT_OFF_CTRL, 32'hA5000001);
        settle;
        chk("fault", 32'h1, wdt_fault);
        chk("irq", 32'h1, irq);
        chk("reqs", 32'h0, {reset_all_req, reset_proc_req});
        // mask, unmask, then clear the interrupt status
        wr(`WWDT_OFF_IRQ_STAT, 32'h0);
        settle;
        chk("irq", 32'h0, irq);
        wr(`WWDT_OFF_IRQ_STAT, 32'h00000300);
        settle;
        chk("irq", 32'h1, irq);
        wr(`WWDT_OFF_IRQ_STAT, 32'h00000302);
        settle;
        chk("irq", 32'h0, irq);
        chk("fault", 32'h1, wdt_fault);
        rd(`WWDT_OFF_STAT, 32'h2, "status");
        rd(`WWDT_OFF_STAT, 32'h0, "status");
        chk("fault", 32'h0, wdt_fault);
        // error did not reload: underflow at 4*128 ticks of 4 clocks
        repeat (1800) @(posedge clk);
        #1 chk("early", 32'h0, irq);
        wait_ev(600);
        chk("irq", 32'h1, irq);
        chk("fault", 32'h0, wdt_fault);
        rd(`WWDT_OFF_STAT, 32'h1, "status");
        // reset enabled, all resets then processor only
        for (k = 0; k < 2; k = k + 1)
        begin
            sw_rst <= 1'b1;
            @(posedge clk);
            sw_rst <= 1'b0;
            repeat (20) @(posedge clk);
            rd(`WWDT_OFF_MODE, `WWDT_MODE_RESET, "mode");
            wr(`WWDT_OFF_MODE, k ? 32'h0FFF6001 : 32'h0FFF2001);
            wr(`WWDT_OFF_CTRL, 32'hA5000001);
            rd(`WWDT_OFF_STAT, 32'h0, "status");
            wait_ev(1500);
            chk("proc", k, reset_proc_req);
            chk("all", !k, reset_all_req);
            chk("irq", 32'h0, irq);
            repeat (20) @(posedge clk);
            rd(`WWDT_OFF_STAT, 32'h0, "status");
            rd(`WWDT_OFF_MODE, `WWDT_MODE_RESET, "mode");
        end
        // disabled: no underflow, window errors still flagged
        wr(`WWDT_OFF_MODE, 32'h00009001);
        repeat (1500) @(posedge clk);
        #1 chk("irq", 32'h0, irq);
        wr(`WWDT_OFF_CTRL, 32'hA5000001);
        settle;
        chk("irq", 32'h1, irq);
        chk("reqs", 32'h0, {reset_all_req, reset_proc_req});
        rd(`WWDT_OFF_STAT, 32'h2, "status");
        // debug halt freezes the count; idle runs on with its halt bit clear
        @(posedge clk);
        sw_rst <= 1'b1;
        debug_state <= 1'b1;
        @(posedge clk);
        sw_rst <= 1'b0;
        repeat (20) @(posedge clk);
        wr(`WWDT_OFF_MODE, 32'h10FF1001);
        repeat (1500) @(posedge clk);
        #1 chk("halt", 32'h0, irq);
        @(posedge clk);
        debug_state <= 1'b0;
        idle_state <= 1'b1;
        // a restart mid-period must also restart the prescaler
        repeat (400) @(posedge clk);
        wr(`WWDT_OFF_CTRL, 32'hA5000001);
        repeat (700) @(posedge clk);
        #1 chk("restart", 32'h0, irq);
        wait_ev(600);
        chk("idle", 32'h1, irq);
        rd(`WWDT_OFF_STAT, 32'h1, "status");
        tally_and_finish;
    end
endmodule

bind wwdt_top wwdt_top_properties wwdt_top_properties_inst (.clk(clk),
    .rstn(rstn), .proc_rst_n(proc_rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .wdt_fault(wdt_fault),
    .reset_all_req(reset_all_req), .reset_proc_req(reset_proc_req));

/* File: verif/wwdt_rstc_model.sv */
`timescale 1ns/1ps

module wwdt_rstc_model
(
    // clock and backup reset
    input wire clk,
    input wire rstn,
    // requests from watchdog and bench
    input wire reset_all_req,
    input wire reset_proc_req,
    input wire sw_rst,
    // to the watchdog
    output reg slow_clk_in,
    output reg proc_rst_n
);
    reg [1:0] div_reg;
    reg [2:0] hold_reg;

    // slow oscillator is permanent, so it runs free at clk/4
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_reg <= 2'h0;
            slow_clk_in <= 1'b0;
        end
        else
        begin
            div_reg <= div_reg + 2'h1;
            slow_clk_in <= div_reg[1];
        end
    end

    // any request resets the processor, and the watchdog with it
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_reg <= 3'h0;
            proc_rst_n <= 1'b1;
        end
        else if (reset_all_req || reset_proc_req || sw_rst)
        begin
            hold_reg <= 3'h6;
            proc_rst_n <= 1'b0;
        end
        else
        begin
            hold_reg <= (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;
            proc_rst_n <= (hold_reg <= 3'h1);
        end
    end
endmodule

/* File: verif/wwdt_top_properties.sv */
`timescale 1ns/1ps
`include "wwdt_regs.vh"

module wwdt_top_properties
(
    // clock and backup reset
    input wire clk,
    input wire rstn,
    // watched pins
    input wire proc_rst_n,
    input wire [`WWDT_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire irq,
    input wire wdt_fault,
    input wire reset_all_req,
    input wire reset_proc_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // status read strobe, used by the clearing checks
    wire st_rd = reg_rd && reg_addr == `WWDT_OFF_STAT;

    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    property p_stat_bits;
        st_rd |=> reg_rdata[31:2] == 30'h0;
    endproperty
    a_stat_bits: assert property (p_stat_bits)
        else $error("status upper bits set");
    property p_mode_bits;
        reg_rd && reg_addr == `WWDT_OFF_MODE |=> reg_rdata[31:30] == 2'h0;
    endproperty
    a_mode_bits: assert property (p_mode_bits)
        else $error("mode reserved bits set");
    property p_req_excl;
        !(reset_all_req && reset_proc_req);
    endproperty
    a_req_excl: assert property (p_req_excl)
        else $error("both reset requests");
    property p_req_fault;
        reset_all_req || reset_proc_req |-> wdt_fault;
    endproperty
    a_req_fault: assert property (p_req_fault)
        else $error("reset request without fault");
    property p_rd_clear;
        st_rd |-> ##2 !wdt_fault && !irq;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("status read did not clear");
    // a held processor reset must clear the fault, interrupt and both reset request outputs
    property p_proc_clear;
        !proc_rst_n [*3] |-> ##2 !wdt_fault && !irq && !reset_all_req
            && !reset_proc_req;
    endproperty
    a_proc_clear: assert property (p_proc_clear)
        else $error("processor reset left outputs");
    property p_fault_hold;
        $fell(wdt_fault) |-> $past(st_rd, 2) || !$past(proc_rst_n, 3);
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault dropped without cause");
    property p_bad_key;
        reg_wr && reg_addr == `WWDT_OFF_CTRL && !wdt_fault && !$past(reg_wr)
            && reg_wdata[31:24] != `WWDT_KEY_VALUE |-> ##2 !wdt_fault;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("wrong key write acted");

    c_irq: cover property ($rose(irq));
    c_proc: cover property ($rose(reset_proc_req));
    c_all: cover property ($rose(reset_all_req));
endmodule

/* File: verilog/wwdt_regs.vh */
`ifndef WWDT_REGS_VH
`define WWDT_REGS_VH

// byte offsets of the register map
`define WWDT_OFF_CTRL 4'h0
`define WWDT_OFF_MODE 4'h4
`define WWDT_OFF_STAT 4'h8
`define WWDT_OFF_IRQ_STAT 4'hC
`define WWDT_ADDR_W 4

// restart_control fields
`define WWDT_KEY_HI 31
`define WWDT_KEY_LO 24
`define WWDT_KEY_VALUE 8'hA5
`define WWDT_RESTART_BIT 0

// watchdog_mode fields
`define WWDT_MODE_RESET 32'h3FFF2FFF
`define WWDT_MODE_MASK 32'h3FFFFFFF
`define WWDT_RELOAD_HI 11
`define WWDT_RELOAD_LO 0
`define WWDT_FIEN_BIT 12
`define WWDT_RSTEN_BIT 13
`define WWDT_PROCSEL_BIT 14
`define WWDT_DIS_BIT 15
`define WWDT_DELTA_HI 27
`define WWDT_DELTA_LO 16
`define WWDT_DBGHLT_BIT 28
`define WWDT_IDLEHLT_BIT 29

// watchdog_status fields
`define WWDT_UNF_BIT 0
`define WWDT_ERR_BIT 1

// interrupt registers: status in [1:0], mask in [9:8] of the same word
`define WWDT_IRQ_MASK_LO 8
`define WWDT_IRQ_STAT_HI 1
`define WWDT_IRQ_STAT_LO 0
`define WWDT_IRQ_MASK_RESET 2'h3

// counter and prescaler
`define WWDT_CNT_W 12
`define WWDT_CNT_ZERO 12'h000
`define WWDT_PRE_W 7
`define WWDT_PRE_LAST 7'h7F
`define WWDT_PRE_ZERO 7'h00
`define WWDT_PRE_ONE 7'h01
`define WWDT_CNT_ONE 12'h001
`define WWDT_RELOAD_RESET 12'hFFF

`endif

/* File: verilog/wwdt_top.v */
// What this block does
// [RULE1] 12-bit down counter reloads from the mode register's counter field.
// [RULE2] counter decrements once per 128 slow clock periods.
// [RULE3] after reset counter field is 0xFFF, watchdog runs, reset enable set.
// [RULE4] mode register takes only its first write until processor reset.
// [RULE5] accepted mode write reloads counter and restarts counting.
// [RULE6] control writes act only when the key byte is 0xA5.
// [RULE7] keyed in-window restart reloads counter and restarts the prescaler.
// [RULE8] underflow sets underflow flag, raises fault if reset enable set.
// [RULE9] restart above delta sets error and fault, even when disabled.
// [RULE10] restart at or below delta is accepted; large delta disables check.
// [RULE11] faults raise the interrupt only with the interrupt enable bit set.
// [RULE12] fault requests all resets or processor reset only, if enabled.
// [RULE13] watchdog-caused processor reset resets the block and its flags; the interrupt mask keeps its value.
// [RULE14] status read or reset clears flags, interrupt and fault line.
// [RULE15] counter halts in debug or idle state when the halt bits say so.
// [RULE16] disable bit set stops the watchdog, clear enables it.
// [RULE17] mode layout: reload 11:0, enables 15:12, delta 27:16.
// [RULE18] status holds sticky underflow at bit 0 and error at bit 1.
// [RULE19] while disabled no decrement and no underflow; window errors remain.
`timescale 1ns/1ps
`include "wwdt_regs.vh"

module wwdt_top
(
    // clock and backup reset
    input wire clk,
    input wire rstn,
    // pins from outside this clock domain
    input wire slow_clk_in,
    input wire proc_rst_n,
    input wire debug_state,
    input wire idle_state,
    // register port
    input wire [`WWDT_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // to interrupt controller
    output reg irq,
    // to reset controller
    output reg wdt_fault,
    output reg reset_all_req,
    output reg reset_proc_req
);

    // two-flop synchronisers; stage one feeds stage two only
    reg slck_s1_reg;
    reg slck_s2_reg;
    reg slck_d_reg;
    reg prst_s1_reg;
    reg prst_s2_reg;
    reg dbg_s1_reg;
    reg dbg_s2_reg;
    reg idle_s1_reg;
    reg idle_s2_reg;

    // block state
    reg [31:0] watchdog_mode_reg;
    reg mode_locked_reg;
    reg [`WWDT_CNT_W-1:0] count_reg;
    reg [`WWDT_PRE_W-1:0] presc_reg;
    reg underflow_flag_reg;
    reg window_error_flag_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg fault_reg;

    // next values
    reg [31:0] watchdog_mode_next;
    reg mode_locked_next;
    reg [`WWDT_CNT_W-1:0] count_next;
    reg [`WWDT_PRE_W-1:0] presc_next;
    reg underflow_flag_next;
    reg window_error_flag_next;
    reg [1:0] irq_stat_next;
    reg [1:0] irq_mask_next;
    reg fault_next;
    reg [31:0] rdata_next;

    // decoded fields of the mode register
    wire [`WWDT_CNT_W-1:0] counter_reload_field;
    wire [`WWDT_CNT_W-1:0] restart_window_delta;
    wire fault_interrupt_enable;
    wire fault_reset_enable;
    wire processor_only_reset_select;
    wire watchdog_disable;
    wire debug_halt;
    wire idle_halt;

    // decoded bus, timer and reset events
    wire wr_ctrl;
    wire wr_mode;
    wire wr_irq;
    wire rd_stat;
    wire key_ok;
    wire restart_req;
    wire in_window;
    wire slow_edge;
    wire halted;
    wire tick;
    wire underflow_evt;
    wire error_evt;
    wire proc_rst_active;

    // one strobe at one exact offset; the four strobe decodes share this, not the read mux
    function wwdt_hit;
        input strobe;
        input [`WWDT_ADDR_W-1:0] addr;
        input [`WWDT_ADDR_W-1:0] offset;
        begin
            wwdt_hit = strobe && (addr == offset);
        end
    endfunction

    // a fault is a reset request only with reset enable; select picks which
    function wwdt_req;
        input fault;
        input enable;
        input proc_sel;
        input want_proc;
        begin
            wwdt_req = fault && enable && (proc_sel == want_proc);
        end
    endfunction

    // [RULE17] field layout of the mode register
    assign counter_reload_field =
        watchdog_mode_reg[`WWDT_RELOAD_HI:`WWDT_RELOAD_LO];
    assign restart_window_delta =
        watchdog_mode_reg[`WWDT_DELTA_HI:`WWDT_DELTA_LO];
    assign fault_interrupt_enable = watchdog_mode_reg[`WWDT_FIEN_BIT];
    assign fault_reset_enable = watchdog_mode_reg[`WWDT_RSTEN_BIT];
    assign processor_only_reset_select =
        watchdog_mode_reg[`WWDT_PROCSEL_BIT];
    assign watchdog_disable = watchdog_mode_reg[`WWDT_DIS_BIT];
    assign debug_halt = watchdog_mode_reg[`WWDT_DBGHLT_BIT];
    assign idle_halt = watchdog_mode_reg[`WWDT_IDLEHLT_BIT];

    // address decode of the strobes
    assign wr_ctrl = wwdt_hit(reg_wr, reg_addr, `WWDT_OFF_CTRL);
    assign wr_mode = wwdt_hit(reg_wr, reg_addr, `WWDT_OFF_MODE);
    assign wr_irq = wwdt_hit(reg_wr, reg_addr, `WWDT_OFF_IRQ_STAT);
    assign rd_stat = wwdt_hit(reg_rd, reg_addr, `WWDT_OFF_STAT);

    // a wrong key throws the whole write away
    assign key_ok =
        (reg_wdata[`WWDT_KEY_HI:`WWDT_KEY_LO] == `WWDT_KEY_VALUE); // RULE6
    assign restart_req =
        wr_ctrl && key_ok && reg_wdata[`WWDT_RESTART_BIT]; // RULE6
    // delta at or above reload value makes every count legal
    assign in_window = (count_reg <= restart_window_delta); // RULE10
    // window check ignores the disable bit on purpose
    assign error_evt = restart_req && !in_window; // RULE9

    // slow clock is sampled, so one tick per rising edge seen here
    assign slow_edge = slck_s2_reg && !slck_d_reg;
    assign halted = (debug_halt && dbg_s2_reg) ||
                    (idle_halt && idle_s2_reg); // RULE15
    assign tick = slow_edge && !halted && !watchdog_disable &&
                  (presc_reg == `WWDT_PRE_LAST); // RULE2 RULE16 RULE19
    assign underflow_evt = tick && (count_reg == `WWDT_CNT_ZERO); // RULE8
    // processor reset acts two edges after its pin falls
    assign proc_rst_active = !prst_s2_reg;

    // synchronisers for pins; proc reset idles released
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            slck_s1_reg <= 1'b0;
            slck_s2_reg <= 1'b0;
            slck_d_reg <= 1'b0;
            prst_s1_reg <= 1'b1;
            prst_s2_reg <= 1'b1;
            dbg_s1_reg <= 1'b0;
            dbg_s2_reg <= 1'b0;
            idle_s1_reg <= 1'b0;
            idle_s2_reg <= 1'b0;
        end
        else
        begin
            slck_s1_reg <= slow_clk_in;
            slck_s2_reg <= slck_s1_reg;
            slck_d_reg <= slck_s2_reg;
            prst_s1_reg <= proc_rst_n;
            prst_s2_reg <= prst_s1_reg;
            dbg_s1_reg <= debug_state;
            dbg_s2_reg <= dbg_s1_reg;
            idle_s1_reg <= idle_state;
            idle_s2_reg <= idle_s1_reg;
        end
    end

    // mode register: write once, unlocked only by processor reset
    always @*
    begin
        watchdog_mode_next = watchdog_mode_reg;
        mode_locked_next = mode_locked_reg;
        if (proc_rst_active)
        begin
            watchdog_mode_next = `WWDT_MODE_RESET; // RULE3 RULE4
            mode_locked_next = 1'b0; // RULE4
        end
        else if (wr_mode && !mode_locked_reg)
        begin
            watchdog_mode_next = reg_wdata & `WWDT_MODE_MASK; // RULE4
            mode_locked_next = 1'b1; // RULE4
        end
    end

    // counter and prescaler
    always @*
    begin
        count_next = count_reg;
        presc_next = presc_reg;
        if (proc_rst_active)
        begin
            // reset value of the mode register's reload field
            count_next = `WWDT_RELOAD_RESET; // RULE3 RULE13
            presc_next = `WWDT_PRE_ZERO;
        end
        else if (wr_mode && !mode_locked_reg)
        begin
            // new parameters take effect from a fresh period
            count_next = reg_wdata[`WWDT_RELOAD_HI:`WWDT_RELOAD_LO]; // RULE5
            presc_next = `WWDT_PRE_ZERO; // RULE5
        end
        else if (restart_req && in_window)
        begin
            count_next = counter_reload_field; // RULE7 RULE10 RULE1
            presc_next = `WWDT_PRE_ZERO; // RULE7
        end
        else if (slow_edge && !halted && !watchdog_disable)
        begin
            // prescaler freezes with the counter while halted or disabled
            presc_next = presc_reg + `WWDT_PRE_ONE; // RULE2 RULE15 RULE19
            // after underflow the counter reloads and keeps counting
            if (underflow_evt)
                count_next = counter_reload_field; // RULE1
            else if (tick)
                count_next = count_reg - `WWDT_CNT_ONE; // RULE1
        end
    end

    // sticky flags: an event in the clearing cycle keeps its flag set
    always @*
    begin
        underflow_flag_next = underflow_flag_reg;
        window_error_flag_next = window_error_flag_reg;
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        fault_next = fault_reg;
        if (proc_rst_active)
        begin
            underflow_flag_next = 1'b0; // RULE13 RULE14
            window_error_flag_next = 1'b0; // RULE13 RULE14
            irq_stat_next = 2'h0; // RULE14
            fault_next = 1'b0; // RULE14
        end
        else
        begin
            // reading status acknowledges every fault at once
            if (rd_stat)
            begin
                underflow_flag_next = 1'b0; // RULE14
                window_error_flag_next = 1'b0; // RULE14
                irq_stat_next = 2'h0; // RULE14
                fault_next = 1'b0; // RULE14
            end
            // write-one-to-clear status and a new mask in the same word
            if (wr_irq)
            begin
                irq_stat_next = irq_stat_reg &
                    ~reg_wdata[`WWDT_IRQ_STAT_HI:`WWDT_IRQ_STAT_LO];
                irq_mask_next =
                    reg_wdata[`WWDT_IRQ_MASK_LO+1:`WWDT_IRQ_MASK_LO];
            end
            if (underflow_evt)
            begin
                underflow_flag_next = 1'b1; // RULE8 RULE18
                irq_stat_next[`WWDT_UNF_BIT] = 1'b1;
                if (fault_reset_enable)
                    fault_next = 1'b1; // RULE8
            end
            if (error_evt)
            begin
                window_error_flag_next = 1'b1; // RULE9 RULE18
                irq_stat_next[`WWDT_ERR_BIT] = 1'b1;
                fault_next = 1'b1; // RULE9
            end
        end
    end

    // read mux; unmapped and write-only offsets read as zero
    always @*
    begin
        rdata_next = 32'h00000000;
        if (reg_rd)
        begin
            case (reg_addr)
                `WWDT_OFF_MODE:
                    rdata_next = watchdog_mode_reg; // RULE17
                `WWDT_OFF_STAT:
                begin
                    rdata_next[`WWDT_UNF_BIT] = underflow_flag_reg; // RULE18
                    rdata_next[`WWDT_ERR_BIT] =
                        window_error_flag_reg; // RULE18
                end
                `WWDT_OFF_IRQ_STAT:
                begin
                    rdata_next[`WWDT_IRQ_STAT_HI:`WWDT_IRQ_STAT_LO] =
                        irq_stat_reg;
                    rdata_next[`WWDT_IRQ_MASK_LO+1:`WWDT_IRQ_MASK_LO] =
                        irq_mask_reg;
                end
                default:
                    rdata_next = 32'h00000000;
            endcase
        end
    end

    // state registers
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            watchdog_mode_reg <= `WWDT_MODE_RESET; // RULE3
            mode_locked_reg <= 1'b0;
            count_reg <= `WWDT_RELOAD_RESET; // RULE3
            presc_reg <= `WWDT_PRE_ZERO;
            underflow_flag_reg <= 1'b0;
            window_error_flag_reg <= 1'b0;
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= `WWDT_IRQ_MASK_RESET;
            fault_reg <= 1'b0;
        end
        else
        begin
            watchdog_mode_reg <= watchdog_mode_next;
            mode_locked_reg <= mode_locked_next;
            count_reg <= count_next;
            presc_reg <= presc_next;
            underflow_flag_reg <= underflow_flag_next;
            window_error_flag_reg <= window_error_flag_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            fault_reg <= fault_next;
        end
    end

    // outputs straight from flops, one cycle behind the state
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 32'h00000000;
            irq <= 1'b0;
            wdt_fault <= 1'b0;
            reset_all_req <= 1'b0;
            reset_proc_req <= 1'b0;
        end
        else
        begin
            reg_rdata <= rdata_next;
            irq <= fault_interrupt_enable &&
                   (|(irq_stat_reg & irq_mask_reg)); // RULE11
            wdt_fault <= fault_reg;
            reset_all_req <= wwdt_req(fault_reg, fault_reset_enable,
                processor_only_reset_select, 1'b0); // RULE12
            reset_proc_req <= wwdt_req(fault_reg, fault_reset_enable,
                processor_only_reset_select, 1'b1); // RULE12
        end
    end

endmodule
